/* File: design/gcs_divider.sv */
// Purpose: one-cycle tick every period cycles while enabled
// Assumes: period of at least one
// Notes:   restarts from zero whenever disabled
`timescale 1ns/1ps
module gcs_divider #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         enable,
    input  wire logic [W-1:0] period,
    // Tick out
    output logic              tick
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;

    // Count to period minus one, then pulse
    always_comb begin
        next_cnt  = '0;
        next_tick = 1'b0;
        if (enable) begin
            if (cnt >= period - W'(1)) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : gcs_divider

/* File: design/gcs_irq.sv */
// Purpose: sticky completion status, mask gating, level interrupt
// Assumes: clear only removes bits that the read actually returned
// Notes:   a new event beats a clear in the same cycle
`timescale 1ns/1ps
module gcs_irq (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Event side
    gcs_irq_if.unit   ev
);
    logic next_status;

    // Set wins over the read clear
    always_comb begin
        next_status = (ev.status & ~ev.status_clr) | ev.done_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev.status <= 1'b0;
            ev.irq    <= 1'b0;
        end else begin
            ev.status <= next_status;
            ev.irq    <= next_status & ev.mask;
        end
    end
endmodule : gcs_irq

/* File: design/gcs_irq_if.sv */
// Purpose: carries completion events and status between sequencer and interrupt unit
// Assumes: single clock pclk
// Notes:   one event source today, widen with the status register
`timescale 1ns/1ps
interface gcs_irq_if;
    logic done_evt;
    logic status_clr;
    logic mask;
    logic status;
    logic irq;
    modport src  (output done_evt, output status_clr, output mask, input status, input irq);
    modport unit (input done_evt, input status_clr, input mask, output status, output irq);
endinterface : gcs_irq_if

/* File: design/gcs_pkg.sv */
// Purpose: shared types of the converter sequencer
// Assumes: nothing beyond the register header
// Notes:   Gray codes along off, settle, sample, convert, wait
package gcs_pkg;
    typedef enum logic [2:0] {
        GCS_OFF     = 3'h0,
        GCS_SETTLE  = 3'h1,
        GCS_SAMPLE  = 3'h3,
        GCS_CONVERT = 3'h2,
        GCS_WAIT    = 3'h6
    } gcs_state_type;
    typedef logic [9:0] gcs_result_type;
endpackage : gcs_pkg

/* File: design/gcs_regs.svh */
// Purpose: register offsets, field positions and timing figures
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef GCS_REGS_SVH
`define GCS_REGS_SVH
`define GCS_OFF_CTRL    8'h00
`define GCS_OFF_CTRL2   8'h04
`define GCS_OFF_CTRL3   8'h08
`define GCS_OFF_STAT    8'h0C
`define GCS_OFF_MASK    8'h10
`define GCS_OFF_STATE   8'h14
`define GCS_OFF_RESULT  8'h18
`define GCS_B_EN        0
`define GCS_B_START     1
`define GCS_B_CONT      2
`define GCS_B_SE        3
`define GCS_B_ACLK      4
`define GCS_B_CCLK      5
`define GCS_F_CHAN      11:8
`define GCS_CTRL_WMASK  32'h0000_0F3D
`define GCS_B_ATTN      0
`define GCS_F_SMPL      5:4
`define GCS_CTRL2_WMASK 32'h0000_0031
`define GCS_F_ENDEL     7:0
`define GCS_F_IVAL      15:8
`define GCS_CTRL3_WMASK 32'h0000_FFFF
`define GCS_RST_REG     32'h0000_0000
`define GCS_CH_BAT      4'h8
`define GCS_CH_GND      4'h9
`define GCS_CH_PAIR     4'h1
`define GCS_PCLK_MHZ    20
`define GCS_CONV_MHZ    16
`define GCS_CCLK_LO_MHZ 16
`define GCS_CCLK_HI_MHZ 96
`define GCS_EN_UNIT_CLK 32
`define GCS_MS_US       1000
`endif

/* File: design/gcs_sequencer.sv */
// Purpose: enable sequence, conversion handshake and continuous mode of the converter
// Assumes: APB slave, 20 MHz pclk, analog core result quasi-static after a conversion
// Notes:   converter clocks are modelled as pclk tick enables
// Behaviour
// - Enable turns regulator on, waits the delay count, then enables the converter.
// - Enabled and idle, the converter samples the selected channel.
// - Writing 1 to start ends sampling and launches conversion.
// - On completion start clears, sampling resumes and the interrupt is raised.
// - Conversion lasts about one 16 MHz period.
// - Continuous mode relaunches each conversion automatically after the previous.
// - Interval zero restarts at once; nonzero spaces conversions by that many ms.
// - Nonzero interval launches align to a 1 ms tick.
// - Select bit chooses eight single-ended channels or two differential pairs.
// - Attenuation triples the input scale to 0 to 3.6 V.
// - Channel selector also routes battery supply and analog ground.
// - Analog core clock 100 MHz or converter clock; logic clock 16 or 96 MHz.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "gcs_regs.svh"
module gcs_sequencer #(
    parameter int MS_CYCLES = `GCS_MS_US * `GCS_PCLK_MHZ
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Analog core
    input  wire gcs_pkg::gcs_result_type core_result,
    output logic                        regulator_en,
    output logic                        converter_en,
    output logic                        sample_phase,
    output logic                        convert_start,
    output logic [3:0]                  mux_sel,
    output logic                        single_ended,
    output logic                        attenuation,
    output logic                        analog_clk_sel,
    output logic                        conv_clk_sel,
    output logic [1:0]                  sampling_time,
    // System
    output logic                        dma_req,
    output logic                        conversion_done_irq
);
    import gcs_pkg::*;

    // Converter periods as pclk counts, rounded up so no delay ever comes out short
    localparam int CONV_CYC = (`GCS_PCLK_MHZ + `GCS_CONV_MHZ - 1) / `GCS_CONV_MHZ;
    localparam int UNIT_LO  = (`GCS_EN_UNIT_CLK * `GCS_PCLK_MHZ + `GCS_CCLK_LO_MHZ - 1) / `GCS_CCLK_LO_MHZ;
    localparam int UNIT_HI  = (`GCS_EN_UNIT_CLK * `GCS_PCLK_MHZ + `GCS_CCLK_HI_MHZ - 1) / `GCS_CCLK_HI_MHZ;

    gcs_irq_if     irq_bus ();
    gcs_state_type state, next_state;
    logic [31:0]   ctrl, ctrl2, ctrl3, next_ctrl, next_ctrl2, next_ctrl3;
    logic [31:0]   next_prdata;
    logic          next_pready, next_pslverr;
    logic          mask, next_mask;
    logic [7:0]    cnt, next_cnt, ms, next_ms;
    logic          next_reg_on, next_conv_on, next_sample, next_launch;
    logic [3:0]    next_mux;
    logic          fsm_done, start_clr, set_start, wr_go, rd_go;
    logic          unit_tick, ms_tick, gated;
    logic [9:0]    res_meta, res_sync, result, next_result;
    logic [5:0]    unit_period;

    assign wr_go  = psel & penable & pready & pwrite;
    assign rd_go  = psel & penable & pready & ~pwrite;
    assign gated  = ctrl[`GCS_B_CONT] & (ctrl3[`GCS_F_IVAL] != 8'h00);
    assign unit_period = conv_clk_sel ? 6'(UNIT_HI) : 6'(UNIT_LO);

    // Settling unit tick, one per 32 converter clocks
    gcs_divider #(.W(6)) u_unit_div (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (state == GCS_SETTLE),
        .period  (unit_period),
        .tick    (unit_tick)
    );

    // Free-running 1 ms tick while the converter is on
    gcs_divider #(.W(16)) u_ms_div (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (converter_en),
        .period  (16'(MS_CYCLES)),
        .tick    (ms_tick)
    );

    // Completion status and interrupt
    gcs_irq u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .ev      (irq_bus.unit)
    );

    assign irq_bus.done_evt   = fsm_done;
    assign irq_bus.mask       = mask;
    assign irq_bus.status_clr = rd_go & (paddr == `GCS_OFF_STAT) & prdata[0];
    assign conversion_done_irq = irq_bus.irq;

    // Result pins cross from the analog side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_meta <= 10'h000;
            res_sync <= 10'h000;
        end else begin
            res_meta <= core_result;
            res_sync <= res_meta;
        end
    end

    // Register file and one-wait-state APB answer
    always_comb begin
        next_ctrl    = ctrl;
        next_ctrl2   = ctrl2;
        next_ctrl3   = ctrl3;
        next_mask    = mask;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        set_start    = 1'b0;
        next_result  = fsm_done ? res_sync : result;
        if (psel & penable & ~pready) begin
            next_pready = 1'b1;
            case (paddr)
                `GCS_OFF_CTRL:   next_prdata = ctrl;
                `GCS_OFF_CTRL2:  next_prdata = ctrl2;
                `GCS_OFF_CTRL3:  next_prdata = ctrl3;
                `GCS_OFF_STAT:   next_prdata = {31'h0000_0000, irq_bus.status};
                `GCS_OFF_MASK:   next_prdata = {31'h0000_0000, mask};
                `GCS_OFF_STATE:  next_prdata = {29'h0000_0000, state};
                `GCS_OFF_RESULT: next_prdata = {22'h00_0000, result};
                default: begin
                    next_prdata  = 32'h0000_0000;
                    next_pslverr = 1'b1; // Unmapped address
                end
            endcase
        end
        if (wr_go) begin
            case (paddr)
                `GCS_OFF_CTRL: begin
                    next_ctrl = (pwdata & `GCS_CTRL_WMASK) | (ctrl & ~`GCS_CTRL_WMASK);
                    set_start = pwdata[`GCS_B_START] & pwdata[`GCS_B_EN];
                end
                `GCS_OFF_CTRL2: next_ctrl2 = pwdata & `GCS_CTRL2_WMASK;
                `GCS_OFF_CTRL3: next_ctrl3 = pwdata & `GCS_CTRL3_WMASK;
                `GCS_OFF_MASK:  next_mask  = pwdata[0];
                default: begin
                end
            endcase
        end
        // Start is set only by software, cleared by hardware; the set wins
        next_ctrl[`GCS_B_START] = (ctrl[`GCS_B_START] & ~start_clr & next_ctrl[`GCS_B_EN]) | set_start;
        // Differential mode only has two pairs; battery and ground pass through
        if (next_ctrl[`GCS_F_CHAN] >= `GCS_CH_BAT) begin
            next_mux = next_ctrl[`GCS_F_CHAN];
        end else if (next_ctrl[`GCS_B_SE]) begin
            next_mux = next_ctrl[`GCS_F_CHAN];
        end else begin
            next_mux = next_ctrl[`GCS_F_CHAN] & `GCS_CH_PAIR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl           <= `GCS_RST_REG;
            ctrl2          <= `GCS_RST_REG;
            ctrl3          <= `GCS_RST_REG;
            mask           <= 1'b0;
            prdata         <= `GCS_RST_REG;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            result         <= 10'h000;
            mux_sel        <= 4'h0;
            single_ended   <= 1'b0;
            attenuation    <= 1'b0;
            analog_clk_sel <= 1'b0;
            conv_clk_sel   <= 1'b0;
            sampling_time  <= 2'h0;
        end else begin
            ctrl           <= next_ctrl;
            ctrl2          <= next_ctrl2;
            ctrl3          <= next_ctrl3;
            mask           <= next_mask;
            prdata         <= next_prdata;
            pready         <= next_pready;
            pslverr        <= next_pslverr;
            result         <= next_result;
            mux_sel        <= next_mux;
            single_ended   <= next_ctrl[`GCS_B_SE];
            attenuation    <= next_ctrl2[`GCS_B_ATTN];
            analog_clk_sel <= next_ctrl[`GCS_B_ACLK];
            conv_clk_sel   <= next_ctrl[`GCS_B_CCLK];
            sampling_time  <= next_ctrl2[`GCS_F_SMPL];
        end
    end

    // Sequencer: settle, sample, convert, interval wait
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_ms     = ms;
        next_launch = 1'b0;
        fsm_done    = 1'b0;
        start_clr   = 1'b0;
        case (state)
            GCS_OFF: begin
                if (ctrl[`GCS_B_EN]) begin
                    next_state = GCS_SETTLE;
                    next_cnt   = ctrl3[`GCS_F_ENDEL];
                end
            end
            GCS_SETTLE: begin
                if (cnt == 8'h00) begin
                    next_state = GCS_SAMPLE;
                end else if (unit_tick) begin
                    next_cnt = cnt - 8'h01;
                end
            end
            GCS_SAMPLE: begin
                // Interval mode waits for the ms tick even on the first launch
                if (ctrl[`GCS_B_START] & (~gated | ms_tick)) begin
                    next_state  = GCS_CONVERT;
                    next_cnt    = 8'(CONV_CYC - 1);
                    next_launch = 1'b1;
                end
            end
            GCS_CONVERT: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else begin
                    fsm_done = 1'b1;
                    if (ctrl[`GCS_B_CONT] & ~gated) begin
                        next_cnt    = 8'(CONV_CYC - 1);
                        next_launch = 1'b1;
                    end else if (ctrl[`GCS_B_CONT]) begin
                        next_state = GCS_WAIT;
                        next_ms    = ctrl3[`GCS_F_IVAL];
                    end else begin
                        next_state = GCS_SAMPLE;
                        start_clr  = 1'b1;
                    end
                end
            end
            GCS_WAIT: begin
                if (~ctrl[`GCS_B_CONT]) begin
                    next_state = GCS_SAMPLE;
                    start_clr  = 1'b1;
                end else if (ms_tick) begin
                    if (ms <= 8'h01) begin
                        next_state  = GCS_CONVERT;
                        next_cnt    = 8'(CONV_CYC - 1);
                        next_launch = 1'b1;
                    end else begin
                        next_ms = ms - 8'h01;
                    end
                end
            end
            default: next_state = GCS_OFF;
        endcase
        // Dropping enable powers everything down at once
        if (~ctrl[`GCS_B_EN]) begin
            next_state  = GCS_OFF;
            next_launch = 1'b0;
        end
        next_reg_on  = next_state != GCS_OFF;
        next_conv_on = next_reg_on & (next_state != GCS_SETTLE);
        next_sample  = (next_state == GCS_SAMPLE) | (next_state == GCS_WAIT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= GCS_OFF;
            cnt           <= 8'h00;
            ms            <= 8'h00;
            regulator_en  <= 1'b0;
            converter_en  <= 1'b0;
            sample_phase  <= 1'b0;
            convert_start <= 1'b0;
            dma_req       <= 1'b0;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            ms            <= next_ms;
            regulator_en  <= next_reg_on;
            converter_en  <= next_conv_on;
            sample_phase  <= next_sample;
            convert_start <= next_launch;
            dma_req       <= fsm_done;
        end
    end

    // Checks, all on pclk and quiet during reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    conv_no_regulator_a: assert property (converter_en |-> regulator_en)
        else $error("converter on without regulator");
    settle_hold_a: assert property (state == GCS_SETTLE && cnt != 8'h00 |=> !converter_en)
        else $error("converter on before delay ended");
    idle_sampling_a: assert property (state == GCS_SAMPLE && !ctrl[`GCS_B_START] && ctrl[`GCS_B_EN]
                                      |=> sample_phase)
        else $error("idle converter not sampling");
    start_launch_a: assert property (state == GCS_SAMPLE && ctrl[`GCS_B_START] && !gated
                                     && ctrl[`GCS_B_EN] |=> convert_start && state == GCS_CONVERT)
        else $error("start did not launch conversion");
    conv_length_a: assert property (convert_start && ctrl[`GCS_B_EN] |-> ##2 dma_req)
        else $error("conversion length wrong");
    done_clear_a: assert property (dma_req && state != GCS_CONVERT && state != GCS_WAIT
                                   && state != GCS_OFF |-> !ctrl[`GCS_B_START] && sample_phase)
        else $error("start not cleared on completion");
    cont_restart_a: assert property (fsm_done && ctrl[`GCS_B_CONT] && !gated && ctrl[`GCS_B_EN]
                                     |=> convert_start)
        else $error("continuous mode did not relaunch");
    tick_align_a: assert property (state == GCS_WAIT && !ms_tick |=> !convert_start)
        else $error("interval launch off the ms tick");
    diff_pair_a: assert property (!single_ended && mux_sel < `GCS_CH_BAT |-> mux_sel <= `GCS_CH_PAIR)
        else $error("differential channel out of range");
    done_irq_a: assert property (dma_req && mask |-> conversion_done_irq)
        else $error("unmasked completion without interrupt");
    // Status bit: a read clears it, a completion in the same cycle wins
    status_clear_a: assert property (irq_bus.status_clr && !fsm_done |=> !irq_bus.status)
        else $error("status not cleared by read");
    status_set_a: assert property (fsm_done |=> irq_bus.status)
        else $error("completion lost in status");
    // Power-down is immediate; interval wait keeps tracking the input
    power_down_a: assert property (!ctrl[`GCS_B_EN] |=> !regulator_en && !converter_en)
        else $error("enable cleared but still powered");
    wait_sampling_a: assert property (state == GCS_WAIT |-> sample_phase)
        else $error("interval wait not sampling");

    // Scenarios every full run should reach
    manual_cov: cover property (convert_start ##2 dma_req ##1 !ctrl[`GCS_B_START]);
    slow_settle_cov: cover property (state == GCS_SETTLE && !conv_clk_sel ##1 state == GCS_SAMPLE);
    cont_cov: cover property (dma_req && state == GCS_CONVERT);
    interval_cov: cover property (state == GCS_WAIT ##1 convert_start);
endmodule : gcs_sequencer

/* File: tb/gcs_core_model.sv */
// Purpose: stand-in for the input multiplexer and converter core
// Assumes: result only has to be quasi-static around each conversion
// Notes:   value encodes channel and scale so the bench can predict it
`timescale 1ns/1ps
module gcs_core_model (
    // Selection from the sequencer
    input  wire logic [3:0]              mux_sel,
    input  wire logic                    attenuation,
    // Result to the sequencer
    output gcs_pkg::gcs_result_type      core_result
);
    import gcs_pkg::*;
    // Channel and scale visible in the code, held while selection holds
    assign core_result = {mux_sel, attenuation, 5'h15};
endmodule : gcs_core_model

/* File: tb/test_adc_conversion_sequencer.sv */
// Purpose: self-checking bench of the converter sequencer
// Assumes: one wait state APB slave, shortened millisecond tick
// Notes:   reads queue their expected data, a watcher compares them
`timescale 1ns/1ps
`include "gcs_regs.svh"
module test_adc_conversion_sequencer;
    import gcs_pkg::*;
    localparam int MS    = 50;
    localparam int LIMIT = 6000;
    // Bus side
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h25;
    logic        pready, pslverr, err, mask_on = 1'b0;
    // Core and system side
    gcs_result_type core_result;
    logic        regulator_en, converter_en, sample_phase, convert_start, single_ended, attenuation;
    logic        analog_clk_sel, conv_clk_sel, dma_req, conversion_done_irq;
    logic [3:0]  mux_sel;
    logic [1:0]  sampling_time;
    logic [31:0] rq[$];
    int          fails = 0, n_compared = 0, cyc = 0, t_go = 0, t_dma = 0, gap = 0, n_dma = 0;

    gcs_sequencer #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_result(core_result), .regulator_en(regulator_en),
        .converter_en(converter_en), .sample_phase(sample_phase), .convert_start(convert_start),
        .mux_sel(mux_sel), .single_ended(single_ended), .attenuation(attenuation),
        .analog_clk_sel(analog_clk_sel), .conv_clk_sel(conv_clk_sel), .sampling_time(sampling_time),
        .dma_req(dma_req), .conversion_done_irq(conversion_done_irq));
    gcs_core_model core (.mux_sel(mux_sel), .attenuation(attenuation), .core_result(core_result));

    // 20 MHz clock
    always #25 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic stop_cont(input logic [31:0] c);
        int k;
        k = 0;
        apb(1'b1, `GCS_OFF_CTRL, c);
        do apb(1'b0, `GCS_OFF_CTRL, 32'h0); while (rdat[1] !== 1'b0 && k++ < 80);
        check({31'h0, rdat[1]}, 32'h0);
    endtask : stop_cont

    // Watcher: queued reads, conversion timing, interrupt beside dma
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) check(prdata, rq.pop_front());
        if (dma_req === 1'b1) begin
            check(32'(cyc - t_go), 32'h2);
            check({31'h0, conversion_done_irq}, {31'h0, mask_on});
            gap = cyc - t_dma;
            t_dma = cyc;
            n_dma++;
        end
        if (convert_start === 1'b1) t_go = cyc;
        if (cyc == LIMIT) begin
            fails++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        int n, i;
        logic [3:0] ch;
        logic [31:0] ctrl;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 7; i++) rd(8'(4 * i), `GCS_RST_REG);
        rd(8'h1C, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, `GCS_OFF_CTRL, 32'h2);
        rd(`GCS_OFF_CTRL, 32'h0);
        apb(1'b1, `GCS_OFF_CTRL2, 32'h11);
        rd(`GCS_OFF_CTRL2, 32'h11);
        check({29'h0, attenuation, sampling_time}, 32'h5);
        // Enable with the recommended settle count on the fast converter clock
        ch = 4'(rnd() % 10);
        ctrl = 32'h39 | {20'h0, ch, 8'h0};
        apb(1'b1, `GCS_OFF_CTRL3, 32'h40);
        apb(1'b1, `GCS_OFF_CTRL, ctrl);
        repeat (2) @(posedge pclk);
        check({30'h0, regulator_en, converter_en}, 32'h2);
        n = 0;
        while (converter_en !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n >= 448 && n < 460), 32'h1);
        check({27'h0, sample_phase, mux_sel}, {28'h1, ch});
        check({29'h0, single_ended, conv_clk_sel, analog_clk_sel}, 32'h7);
        // Manual conversion, interrupt unmasked then masked
        for (i = 0; i < 2; i++) begin
            mask_on = (i == 0);
            apb(1'b1, `GCS_OFF_MASK, {31'h0, mask_on});
            apb(1'b1, `GCS_OFF_CTRL, ctrl | 32'h2);
            repeat (5) @(posedge pclk);
            check({31'h0, conversion_done_irq}, {31'h0, mask_on});
            rd(`GCS_OFF_CTRL, ctrl);
            rd(`GCS_OFF_RESULT, {22'h0, ch, 6'h35});
            rd(`GCS_OFF_STAT, 32'h1);
            rd(`GCS_OFF_STAT, 32'h0);
            check({30'h0, conversion_done_irq, sample_phase}, 32'h1);
        end
        // Differential pair selection
        apb(1'b1, `GCS_OFF_CTRL, 32'h321);
        repeat (2) @(posedge pclk);
        check({27'h0, single_ended, mux_sel}, 32'h1);
        // Continuous mode, interval zero then two milliseconds
        n_dma = 0;
        apb(1'b1, `GCS_OFF_CTRL, ctrl | 32'h6);
        repeat (20) @(posedge pclk);
        check(32'(gap), 32'h2);
        check(32'(n_dma >= 6), 32'h1);
        stop_cont(ctrl);
        n = n_dma;
        repeat (6) @(posedge pclk);
        check(32'(n_dma), 32'(n));
        apb(1'b1, `GCS_OFF_CTRL3, 32'h0202);
        n_dma = 0;
        t_dma = cyc;
        apb(1'b1, `GCS_OFF_CTRL, ctrl | 32'h6);
        for (i = 0; i < 8 * MS && n_dma < 3; i++) @(posedge pclk);
        check(32'(n_dma), 32'h3);
        check(32'(gap), 32'(2 * MS));
        stop_cont(ctrl);
        // Disable drops regulator and converter at once
        apb(1'b1, `GCS_OFF_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        check({30'h0, regulator_en, converter_en}, 32'h0);
        rd(`GCS_OFF_STATE, 32'h0);
        // Re-enable on the slow converter clock, 40 pclk per settle unit
        apb(1'b1, `GCS_OFF_CTRL3, 32'h0B);
        apb(1'b1, `GCS_OFF_CTRL, 32'h9);
        n = 0;
        while (converter_en !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n >= 440 && n < 460), 32'h1);
        repeat (2) @(posedge pclk);
        test_done();
    end
endmodule : test_adc_conversion_sequencer
